// >>> rtl/tic_pkg.sv
package tic_pkg;
   localparam int         NUM_TIMERS  = 4;
   localparam int         CNT_W       = 16;
   localparam int         ADDR_W      = 12;
   localparam logic [9:0] IDX_LOOPBACK = 10'h0F8;
   localparam logic [9:0] IDX_DMA_CFG  = 10'h0F9;
   localparam logic [9:0] IDX_MODE     = 10'h0FA;
   localparam logic [9:0] IDX_STATUS   = 10'h0FB;
   localparam logic [9:0] IDX_CAPTURE  = 10'h0FC;
   localparam logic [9:0] IDX_COMPARE  = 10'h0FD;
   localparam logic [9:0] IDX_MASK     = 10'h0FF;
   localparam logic [7:0] LOOPBACK_RST = 8'hFC;
   localparam logic [7:0] MASK_RST     = 8'h00;
   localparam logic [7:0] DMA_CFG_RST  = 8'h00;
   localparam logic [7:0] MODE_RST     = 8'h00;
   localparam logic [15:0] COMPARE_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam int GLOBAL_TIMER_IRQ_ENABLE_BIT = 7;
   localparam int CAPTURE0_DMA_MASK_BIT  = 6;
   localparam int CAPTURE0_IRQ_MASK_BIT  = 5;
   localparam int CAPTURE1_IRQ_MASK_BIT  = 4;
   localparam int COMPARE0_DMA_MASK_BIT  = 3;
   localparam int CM0I_BIT  = 2;
   localparam int DMA_CAPTURE_SOURCE_SEL_BIT  = 5;
   localparam int DMA_COMPARE_DEST_SEL_BIT  = 4;
   localparam int DMA_SWAP_ENABLE_BIT  = 3;
   localparam int PL_LSB    = 0;
   localparam int COMB_BIT  = 0;
   localparam int AUTO_BIT  = 1;
   localparam int BICAP_BIT = 2;
   localparam int UPDN_BIT  = 3;
   localparam int SWCAP_BIT = 4;
   localparam int CAP0F_BIT = 0;
   localparam int CAP1F_BIT = 1;
   localparam int CMP0F_BIT = 2;
   localparam int EOBF_BIT  = 3;
   localparam int IRQ_BIT   = 4;
   localparam int CSEL_BIT  = 5;
endpackage

// >>> rtl/tic_cap_if.sv
`timescale 1ns/1ps
interface tic_cap_if;
   logic                   cap_strobe;
   logic                   bicap_en;
   logic [tic_pkg::CNT_W-1:0] count;
   logic                   cap0_evt;
   logic                   cap1_evt;
   logic [tic_pkg::CNT_W-1:0] cap0;
   logic [tic_pkg::CNT_W-1:0] cap1;
   logic                   cur_sel;
   modport ctrl (output cap_strobe, bicap_en, count,
                 input cap0_evt, cap1_evt, cap0, cap1, cur_sel);
   modport unit (input cap_strobe, bicap_en, count,
                 output cap0_evt, cap1_evt, cap0, cap1, cur_sel);
endinterface

// >>> rtl/tic_pin_sync.sv
`timescale 1ns/1ps
module tic_pin_sync (
   input  wire logic                           core_clk,
   input  wire logic                           srst,
   input  wire logic [tic_pkg::NUM_TIMERS-1:0] pin_a,
   input  wire logic                           pin_b,
   input  wire logic [tic_pkg::NUM_TIMERS-1:0] out_a,
   input  wire logic [1:0]                     loop_sel,
   output logic      [tic_pkg::NUM_TIMERS-1:0] in_a,
   output logic                                in_b
);
   logic [1:0] b_sync_ff;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         b_sync_ff <= 2'h0;
      end else begin
         b_sync_ff <= {b_sync_ff[0], pin_b};
      end
   end
   assign in_b = b_sync_ff[1];

   genvar g;
   generate
      for (g = 0; g < tic_pkg::NUM_TIMERS; g++) begin : g_tmr
         logic [1:0] a_sync_ff;
         logic       a_eff_ff;
         // Odd timers follow bit 1, even timers bit 0.
         always_ff @(posedge core_clk) begin
            if (srst) begin
               a_sync_ff <= 2'h0;
               a_eff_ff  <= 1'b0;
            end else begin
               a_sync_ff <= {a_sync_ff[0], pin_a[g]};
               a_eff_ff  <= loop_sel[g % 2] ? out_a[g] : a_sync_ff[1];
            end
         end
         assign in_a[g] = a_eff_ff;

         property p_loopback;
            @(posedge core_clk) disable iff (srst)
            loop_sel[g % 2] |=> (in_a[g] == $past(out_a[g]));
         endproperty
         a_loopback: assert property (p_loopback)
            else $error("loopback input does not follow output");
      end
   endgenerate
endmodule // tic_pin_sync

// >>> rtl/tic_cap_unit.sv
`timescale 1ns/1ps
module tic_cap_unit (
   input wire logic core_clk,
   input wire logic srst,
   tic_cap_if.unit  cap
);
   logic                      sel_ff;
   logic                      cap0_evt_ff;
   logic                      cap1_evt_ff;
   logic [tic_pkg::CNT_W-1:0] cap0_ff;
   logic [tic_pkg::CNT_W-1:0] cap1_ff;

   // Clearing bicapture returns the pointer to register 0.
   always_ff @(posedge core_clk) begin
      if (srst || !cap.bicap_en) begin
         sel_ff <= 1'b0;
      end else if (cap.cap_strobe) begin
         sel_ff <= ~sel_ff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cap0_ff     <= tic_pkg::COUNT_RST;
         cap1_ff     <= tic_pkg::COUNT_RST;
         cap0_evt_ff <= 1'b0;
         cap1_evt_ff <= 1'b0;
      end else begin
         cap0_evt_ff <= cap.cap_strobe && !sel_ff;
         cap1_evt_ff <= cap.cap_strobe && sel_ff;
         if (cap.cap_strobe && !sel_ff) begin
            cap0_ff <= cap.count;
         end
         if (cap.cap_strobe && sel_ff) begin
            cap1_ff <= cap.count;
         end
      end
   end

   assign cap.cap0_evt = cap0_evt_ff;
   assign cap.cap1_evt = cap1_evt_ff;
   assign cap.cap0     = cap0_ff;
   assign cap.cap1     = cap1_ff;
   assign cap.cur_sel  = sel_ff;

   sequence s_cap_into0;
      cap.cap_strobe && cap.bicap_en && !sel_ff;
   endsequence
   property p_bicap_alt;
      @(posedge core_clk) disable iff (srst)
      s_cap_into0 ##1 cap.bicap_en |-> sel_ff && cap0_evt_ff;
   endproperty
   a_bicap_alt: assert property (p_bicap_alt)
      else $error("bicapture did not alternate");
endmodule // tic_cap_unit

// >>> rtl/tic_irq_dma_ctrl.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
module tic_irq_dma_ctrl (
   input  wire logic                           core_clk,
   input  wire logic                           srst,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [tic_pkg::ADDR_W-1:0]     paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic [tic_pkg::NUM_TIMERS-1:0] timer_input_a,
   input  wire logic                           timer_input_b,
   input  wire logic [tic_pkg::NUM_TIMERS-1:0] timer_output_a,
   output logic      [tic_pkg::NUM_TIMERS-1:0] eff_input_a,
   input  wire logic                           dma_cap_eob,
   input  wire logic                           dma_cmp_eob,
   output logic                                dma_cap_req,
   output logic                                dma_cmp_req,
   output logic                                dma_capture_source_sel,
   output logic                                dma_compare_dest_sel,
   output logic                                dma_swap_enable,
   output logic      [2:0]                     priority_level,
   output logic                                timer_irq_req
);
   logic [7:0]                mask_ff;
   logic [1:0]                loop_ff;
   logic [7:0]                dcfg_ff;
   logic [3:0]                mode_ff;
   logic [tic_pkg::CNT_W-1:0] cmp_ff;
   logic [tic_pkg::CNT_W-1:0] cnt_ff;
   logic [tic_pkg::CNT_W-1:0] nxt_cnt;
   logic                      a_prev_ff;
   logic                      match_prev_ff;
   logic                      cap0f_ff;
   logic                      cap1f_ff;
   logic                      cmp0f_ff;
   logic                      eobf_ff;
   logic                      irq_ff;
   logic                      cap_irq_ff;
   logic                      dma_cap_ff;
   logic                      dma_cmp_ff;
   logic [31:0]               prdata_ff;
   logic                      in_b;
   logic                      a_rise;
   logic                      match;
   logic                      cmp_evt;
   logic                      wr_en;
   logic                      sw_cap;
   logic [9:0]                idx;
   logic                      mapped;
   logic [31:0]               rd_mux;
   logic                      cap0_term;
   logic                      cap1_term;
   logic                      cap_term;
   logic                      nxt_irq;

   tic_cap_if cap ();

   tic_pin_sync u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .pin_a    (timer_input_a),
      .pin_b    (timer_input_b),
      .out_a    (timer_output_a),
      .loop_sel (loop_ff),
      .in_a     (eff_input_a),
      .in_b     (in_b)
   );

   tic_cap_unit u_cap (
      .core_clk (core_clk),
      .srst     (srst),
      .cap      (cap.unit)
   );

   assign idx    = paddr[tic_pkg::ADDR_W-1:2];
   assign mapped = (paddr[1:0] == 2'h0) &&
                   (idx == tic_pkg::IDX_LOOPBACK || idx == tic_pkg::IDX_DMA_CFG ||
                    idx == tic_pkg::IDX_MODE     || idx == tic_pkg::IDX_STATUS  ||
                    idx == tic_pkg::IDX_CAPTURE  || idx == tic_pkg::IDX_COMPARE ||
                    idx == tic_pkg::IDX_MASK);
   assign wr_en  = psel && penable && pwrite && mapped;
   assign sw_cap = wr_en && idx == tic_pkg::IDX_MODE && pwdata[tic_pkg::SWCAP_BIT];

   // Zero wait states: read data is fetched in the setup cycle.
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_ff;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (idx)
         tic_pkg::IDX_LOOPBACK: rd_mux = {24'h0, tic_pkg::LOOPBACK_RST[7:2], loop_ff};
         tic_pkg::IDX_DMA_CFG:  rd_mux = {24'h0, dcfg_ff};
         tic_pkg::IDX_MODE:     rd_mux = {28'h0, mode_ff};
         tic_pkg::IDX_STATUS:   rd_mux = {26'h0, cap.cur_sel, irq_ff, eobf_ff,
                                          cmp0f_ff, cap1f_ff, cap0f_ff};
         tic_pkg::IDX_CAPTURE:  rd_mux = {cap.cap1, cap.cap0};
         tic_pkg::IDX_COMPARE:  rd_mux = {cnt_ff, cmp_ff};
         tic_pkg::IDX_MASK:     rd_mux = {24'h0, mask_ff};
         default:               rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= mapped ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         loop_ff <= tic_pkg::LOOPBACK_RST[1:0];
         dcfg_ff <= tic_pkg::DMA_CFG_RST;
         mode_ff <= tic_pkg::MODE_RST[3:0];
         cmp_ff  <= tic_pkg::COMPARE_RST;
      end else if (wr_en) begin
         case (idx)
            tic_pkg::IDX_LOOPBACK: loop_ff <= pwdata[1:0];
            tic_pkg::IDX_DMA_CFG:  dcfg_ff <= {2'h0, pwdata[5:0]};
            tic_pkg::IDX_MODE:     mode_ff <= pwdata[3:0];
            tic_pkg::IDX_COMPARE:  cmp_ff  <= pwdata[15:0];
            default:               cmp_ff  <= cmp_ff;
         endcase
      end
   end

   // Bits 1:0 of the mask register are kept for software but drive nothing here.
   // End of block wins over a software set in the same cycle; swap keeps the mask.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mask_ff <= tic_pkg::MASK_RST;
      end else begin
         if (wr_en && idx == tic_pkg::IDX_MASK) begin
            mask_ff <= pwdata[7:0];
         end
         if (dma_cap_eob && !dcfg_ff[tic_pkg::DMA_SWAP_ENABLE_BIT]) begin
            mask_ff[tic_pkg::CAPTURE0_DMA_MASK_BIT] <= 1'b0;
         end
         if (dma_cmp_eob && !dcfg_ff[tic_pkg::DMA_SWAP_ENABLE_BIT]) begin
            mask_ff[tic_pkg::COMPARE0_DMA_MASK_BIT] <= 1'b0;
         end
      end
   end

   assign dma_capture_source_sel = dcfg_ff[tic_pkg::DMA_CAPTURE_SOURCE_SEL_BIT];
   assign dma_compare_dest_sel   = dcfg_ff[tic_pkg::DMA_COMPARE_DEST_SEL_BIT];
   assign dma_swap_enable        = dcfg_ff[tic_pkg::DMA_SWAP_ENABLE_BIT];
   assign priority_level         = dcfg_ff[tic_pkg::PL_LSB +: 3];

   // Timer 0 input A drives the capture path and, in autodiscriminator mode, the counter.
   assign a_rise = eff_input_a[0] && !a_prev_ff;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (mode_ff[tic_pkg::AUTO_BIT]) begin
         if (a_rise) begin
            nxt_cnt = in_b ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
         end
      end else if (mode_ff[tic_pkg::UPDN_BIT]) begin
         nxt_cnt = cnt_ff + 16'h0001;
      end else begin
         nxt_cnt = cnt_ff - 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_ff        <= tic_pkg::COUNT_RST;
         a_prev_ff     <= 1'b0;
         match_prev_ff <= 1'b0;
      end else begin
         cnt_ff        <= nxt_cnt;
         a_prev_ff     <= eff_input_a[0];
         match_prev_ff <= match;
      end
   end

   assign match   = (cnt_ff == cmp_ff);
   assign cmp_evt = match && !match_prev_ff;

   assign cap.cap_strobe = a_rise || sw_cap;
   assign cap.bicap_en   = mode_ff[tic_pkg::BICAP_BIT];
   assign cap.count      = cnt_ff;

   // Hardware set wins over a write-one clear in the same cycle.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cap0f_ff <= 1'b0;
         cap1f_ff <= 1'b0;
         cmp0f_ff <= 1'b0;
         eobf_ff  <= 1'b0;
      end else begin
         if (wr_en && idx == tic_pkg::IDX_STATUS) begin
            cap0f_ff <= cap0f_ff & ~pwdata[tic_pkg::CAP0F_BIT];
            cap1f_ff <= cap1f_ff & ~pwdata[tic_pkg::CAP1F_BIT];
            cmp0f_ff <= cmp0f_ff & ~pwdata[tic_pkg::CMP0F_BIT];
            eobf_ff  <= eobf_ff  & ~pwdata[tic_pkg::EOBF_BIT];
         end
         if (cap.cap0_evt) begin
            cap0f_ff <= 1'b1;
         end
         if (cap.cap1_evt) begin
            cap1f_ff <= 1'b1;
         end
         if (cmp_evt) begin
            cmp0f_ff <= 1'b1;
         end
         if (dma_cap_eob) begin
            eobf_ff <= 1'b1;
         end
      end
   end

   // With the capture DMA armed, the capture-0 mask serves the end of block.
   assign cap0_term = mask_ff[tic_pkg::CAPTURE0_IRQ_MASK_BIT] &&
                      (mask_ff[tic_pkg::CAPTURE0_DMA_MASK_BIT] ? eobf_ff : cap0f_ff);
   assign cap1_term = mask_ff[tic_pkg::CAPTURE1_IRQ_MASK_BIT] && cap1f_ff;
   // Combining needs both capture masks set by software to ever fire.
   assign cap_term  = mode_ff[tic_pkg::COMB_BIT] ? (cap0_term && cap1_term)
                                                 : (cap0_term || cap1_term);
   assign nxt_irq   = mask_ff[tic_pkg::GLOBAL_TIMER_IRQ_ENABLE_BIT] &&
                      (cap_term || (mask_ff[tic_pkg::CM0I_BIT] && cmp0f_ff));

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_ff     <= 1'b0;
         cap_irq_ff <= 1'b0;
         dma_cap_ff <= 1'b0;
         dma_cmp_ff <= 1'b0;
      end else begin
         irq_ff     <= nxt_irq;
         cap_irq_ff <= cap_term;
         dma_cap_ff <= mask_ff[tic_pkg::CAPTURE0_DMA_MASK_BIT] && cap.cap0_evt;
         dma_cmp_ff <= mask_ff[tic_pkg::COMPARE0_DMA_MASK_BIT] && cmp_evt;
      end
   end

   assign timer_irq_req = irq_ff;
   assign dma_cap_req   = dma_cap_ff;
   assign dma_cmp_req   = dma_cmp_ff;

   sequence s_step_event;
      mode_ff[tic_pkg::AUTO_BIT] && a_rise;
   endsequence
   property p_auto_up;
      @(posedge core_clk) disable iff (srst)
      s_step_event and in_b |=> cnt_ff == $past(cnt_ff) + 16'h0001;
   endproperty
   a_auto_up: assert property (p_auto_up)
      else $error("autodiscriminator did not count up");

   property p_auto_hold;
      @(posedge core_clk) disable iff (srst)
      mode_ff[tic_pkg::AUTO_BIT] && !a_rise |=> $stable(cnt_ff);
   endproperty
   a_auto_hold: assert property (p_auto_hold)
      else $error("counter moved without a phase event");

   property p_and_combine;
      @(posedge core_clk) disable iff (srst)
      mode_ff[tic_pkg::COMB_BIT] && !cap1f_ff |=> !cap_irq_ff;
   endproperty
   a_and_combine: assert property (p_and_combine)
      else $error("combined capture irq without capture 1");

   property p_or_combine;
      @(posedge core_clk) disable iff (srst)
      !mode_ff[tic_pkg::COMB_BIT] && cap1_term |=> cap_irq_ff;
   endproperty
   a_or_combine: assert property (p_or_combine)
      else $error("single capture did not raise irq");

   property p_global_off;
      @(posedge core_clk) disable iff (srst)
      !mask_ff[tic_pkg::GLOBAL_TIMER_IRQ_ENABLE_BIT] |=> !timer_irq_req;
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("interrupt while globally disabled");

   property p_capture0_dma_mask_clear;
      @(posedge core_clk) disable iff (srst)
      dma_cap_eob && !dma_swap_enable |=> !mask_ff[tic_pkg::CAPTURE0_DMA_MASK_BIT];
   endproperty
   a_capture0_dma_mask_clear: assert property (p_capture0_dma_mask_clear)
      else $error("capture DMA mask not cleared at block end");

   property p_compare0_dma_mask_clear;
      @(posedge core_clk) disable iff (srst)
      dma_cmp_eob && !dma_swap_enable |=> !mask_ff[tic_pkg::COMPARE0_DMA_MASK_BIT];
   endproperty
   a_compare0_dma_mask_clear: assert property (p_compare0_dma_mask_clear)
      else $error("compare DMA mask not cleared at block end");

   property p_eob_irq;
      @(posedge core_clk) disable iff (srst)
      mask_ff[tic_pkg::GLOBAL_TIMER_IRQ_ENABLE_BIT] && mask_ff[tic_pkg::CAPTURE0_IRQ_MASK_BIT] &&
      mask_ff[tic_pkg::CAPTURE0_DMA_MASK_BIT] && eobf_ff && !mode_ff[tic_pkg::COMB_BIT]
      |=> timer_irq_req;
   endproperty
   a_eob_irq: assert property (p_eob_irq)
      else $error("end of block interrupt missing");

   property p_cmp_irq;
      @(posedge core_clk) disable iff (srst)
      mask_ff[tic_pkg::GLOBAL_TIMER_IRQ_ENABLE_BIT] && mask_ff[tic_pkg::CM0I_BIT] && cmp0f_ff
      |=> timer_irq_req;
   endproperty
   a_cmp_irq: assert property (p_cmp_irq)
      else $error("compare interrupt missing");

   property p_cap1_irq;
      @(posedge core_clk) disable iff (srst)
      mask_ff[tic_pkg::GLOBAL_TIMER_IRQ_ENABLE_BIT] && !mask_ff[tic_pkg::CAPTURE1_IRQ_MASK_BIT] &&
      !cap0_term && !cmp0f_ff |=> !timer_irq_req;
   endproperty
   a_cap1_irq: assert property (p_cap1_irq)
      else $error("capture 1 interrupt while masked");

   property p_dma_cap_req;
      @(posedge core_clk) disable iff (srst)
      cap.cap0_evt && !mask_ff[tic_pkg::CAPTURE0_DMA_MASK_BIT] |=> !dma_cap_req;
   endproperty
   a_dma_cap_req: assert property (p_dma_cap_req)
      else $error("capture DMA request while masked");

   property p_priority;
      @(posedge core_clk) disable iff (srst)
      wr_en && idx == tic_pkg::IDX_DMA_CFG |=> priority_level == $past(pwdata[2:0]);
   endproperty
   a_priority: assert property (p_priority)
      else $error("priority level not updated");
endmodule // tic_irq_dma_ctrl

// >>> tb/tic_dma_partner.sv
`timescale 1ns/1ps
module tic_dma_partner #(
   parameter int CAP_LEN = 2,
   parameter int CMP_LEN = 1
) (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic dma_cap_req,
   input  wire logic dma_cmp_req,
   output logic      dma_cap_eob,
   output logic      dma_cmp_eob
);
   int cap_cnt_ff;
   int cmp_cnt_ff;

   // A block ends one edge after its last request, so a longer block answers later.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cap_cnt_ff  <= 0;
         dma_cap_eob <= 1'b0;
      end else begin
         dma_cap_eob <= dma_cap_req && (cap_cnt_ff == CAP_LEN - 1);
         if (dma_cap_req)
            cap_cnt_ff <= (cap_cnt_ff == CAP_LEN - 1) ? 0 : cap_cnt_ff + 1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmp_cnt_ff  <= 0;
         dma_cmp_eob <= 1'b0;
      end else begin
         dma_cmp_eob <= dma_cmp_req && (cmp_cnt_ff == CMP_LEN - 1);
         if (dma_cmp_req)
            cmp_cnt_ff <= (cmp_cnt_ff == CMP_LEN - 1) ? 0 : cmp_cnt_ff + 1;
      end
   end
endmodule // tic_dma_partner

// >>> tb/tic_irq_dma_ctrl_bench.sv
`timescale 1ns/1ps
module tic_irq_dma_ctrl_bench;
   logic        core_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0]  timer_input_a, timer_output_a, eff_input_a;
   logic        timer_input_b, dma_cap_eob, dma_cmp_eob, dma_cap_req, dma_cmp_req;
   logic        dma_capture_source_sel, dma_compare_dest_sel, dma_swap_enable;
   logic [2:0]  priority_level, sel;
   logic        timer_irq_req, rerr;
   logic [15:0] c;
   int          fails, n_compared;

   assign sel = {dma_capture_source_sel, dma_compare_dest_sel, dma_swap_enable};

   tic_irq_dma_ctrl dut_u (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .timer_input_a, .timer_input_b, .timer_output_a,
      .eff_input_a, .dma_cap_eob, .dma_cmp_eob, .dma_cap_req, .dma_cmp_req,
      .dma_capture_source_sel, .dma_compare_dest_sel, .dma_swap_enable, .priority_level,
      .timer_irq_req);

   tic_dma_partner #(.CAP_LEN(2), .CMP_LEN(1)) far_u (.core_clk, .srst, .dma_cap_req,
      .dma_cmp_req, .dma_cap_eob, .dma_cmp_eob);

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      if (fails == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // The extra edge at the end keeps two transfers from driving psel in one time step.
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
      int n;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {idx, 2'b00};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         summarize();
      end
      rdata = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rd(input logic [9:0] idx);
      apb(1'b0, idx, 32'h0);
   endtask

   task automatic cap(input logic [7:0] m);
      wr(tic_pkg::IDX_MODE, {24'h0, m | 8'h10});
      cyc(6);
   endtask

   task automatic pulse(input logic b);
      timer_input_b <= b;
      cyc(4);
      timer_input_a <= 4'h1;
      cyc(8);
      timer_input_a <= 4'h0;
      cyc(8);
   endtask

   task automatic irq_is(input logic e);
      chk("timer_irq_req", {31'h0, timer_irq_req}, {31'h0, e});
   endtask

   task automatic t_regs();
      rd(tic_pkg::IDX_LOOPBACK);
      chk("loopback_reset", rdata, 32'h0000_00FC);
      rd(tic_pkg::IDX_MASK);
      chk("mask_reset", rdata, 32'h0);
      chk("mapped_err", {31'h0, rerr}, 32'h0);
      rd(10'h0FE);
      chk("unmapped_err", {31'h0, rerr}, 32'h1);
      chk("unmapped_data", rdata, 32'h0);
      timer_output_a <= 4'hF;
      for (int i = 0; i < 4; i++) begin
         wr(tic_pkg::IDX_LOOPBACK, i);
         cyc(4);
         rd(tic_pkg::IDX_LOOPBACK);
         chk("loopback", rdata, 32'hFC | i);
         chk("eff_input_a", eff_input_a, {i[1], i[0], i[1], i[0]});
      end
      wr(tic_pkg::IDX_LOOPBACK, 32'h0);
      timer_output_a <= 4'h0;
      for (int i = 0; i < 8; i++) begin
         wr(tic_pkg::IDX_DMA_CFG, {26'h0, i[2:0], i[2:0]});
         chk("priority_level", priority_level, i);
         chk("dma_selects", sel, i);
      end
      wr(tic_pkg::IDX_DMA_CFG, 32'h0);
   endtask

   task automatic t_irq();
      wr(tic_pkg::IDX_STATUS, 32'h0F);
      wr(tic_pkg::IDX_MASK, 32'h20);
      cap(8'h00);
      irq_is(1'b0);
      wr(tic_pkg::IDX_MASK, 32'hA0);
      cyc(2);
      irq_is(1'b1);
      wr(tic_pkg::IDX_STATUS, 32'h0F);
      wr(tic_pkg::IDX_MASK, 32'h90);
      // A strobe in the same write as the bicapture bit is not yet alternated.
      wr(tic_pkg::IDX_MODE, 32'h04);
      cap(8'h04);
      irq_is(1'b0);
      cap(8'h04);
      irq_is(1'b1);
      wr(tic_pkg::IDX_MODE, 32'h05);
      wr(tic_pkg::IDX_STATUS, 32'h0F);
      wr(tic_pkg::IDX_MASK, 32'hB0);
      cap(8'h05);
      irq_is(1'b0);
      cap(8'h05);
      irq_is(1'b1);
      wr(tic_pkg::IDX_STATUS, 32'h0F);
      cap(8'h00);
      irq_is(1'b1);
      wr(tic_pkg::IDX_STATUS, 32'h0F);
      wr(tic_pkg::IDX_MASK, 32'h84);
      irq_is(1'b0);
      rd(tic_pkg::IDX_COMPARE);
      wr(tic_pkg::IDX_COMPARE, {16'h0, rdata[31:16] - 16'h0014});
      cyc(30);
      irq_is(1'b1);
   endtask

   // The compare match is timed to land just after the second capture request has closed the capture block.
   task automatic t_dma(input logic sw);
      wr(tic_pkg::IDX_DMA_CFG, {28'h0, sw, 3'h0});
      wr(tic_pkg::IDX_STATUS, 32'h0F);
      wr(tic_pkg::IDX_MASK, 32'hE8);
      rd(tic_pkg::IDX_COMPARE);
      wr(tic_pkg::IDX_COMPARE, {16'h0, rdata[31:16] - 16'h0014});
      cap(8'h00);
      irq_is(1'b0);
      cap(8'h00);
      cyc(4);
      irq_is(1'b1);
      rd(tic_pkg::IDX_MASK);
      chk("mask_after_eob", rdata, sw ? 32'hE8 : 32'hA0);
   endtask

   task automatic t_auto();
      wr(tic_pkg::IDX_MASK, 32'h0);
      wr(tic_pkg::IDX_MODE, 32'h0A);
      rd(tic_pkg::IDX_COMPARE);
      c = rdata[31:16];
      pulse(1'b0);
      rd(tic_pkg::IDX_COMPARE);
      chk("count_down", rdata[31:16], c - 16'h0001);
      pulse(1'b1);
      rd(tic_pkg::IDX_COMPARE);
      chk("count_up", rdata[31:16], c);
      cap(8'h0E);
      cap(8'h0E);
      pulse(1'b1);
      cap(8'h0E);
      rd(tic_pkg::IDX_CAPTURE);
      // A capture stores the count as it stood before that edge's step.
      chk("capture_one", rdata[31:16], c);
      chk("capture_zero", rdata[15:0], c + 16'h0001);
   endtask

   initial begin
      fails = 0;
      n_compared = 0;
      srst = 1'b1;
      {psel, penable, pwrite, timer_input_b} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      timer_input_a = 4'h0;
      timer_output_a = 4'h0;
      cyc(5);
      srst <= 1'b0;
      t_regs();
      t_irq();
      t_dma(1'b0);
      t_dma(1'b1);
      t_auto();
      summarize();
   end
endmodule // tic_irq_dma_ctrl_bench
